// [damper_control_supervisor.v]
/*
 damper opening command and feedback supervisor with register port and
 interrupt. assumes run command and logic inputs are synchronous to ref_clk.
*/
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "damper_map.vh"

module damper_control_supervisor #(
  parameter NUM_LI      = 6,
  parameter TICK_CYCLES = `DMP_TICK_NS / `DMP_CLK_NS,
  parameter TICK_W      = 24
) (
  // clock and reset
  input  wire              ref_clk,
  input  wire              srst,
  // register port
  input  wire [5:0]        regAddr,
  input  wire [31:0]       wrData,
  input  wire              wrStb,
  input  wire              rdStb,
  output reg  [31:0]       rdData,
  // drive side
  input  wire              runCmd,
  input  wire              analogAssigned,
  input  wire [NUM_LI-1:0] logicIn,
  // damper outputs
  output reg  [3:0]        logicOut,
  output reg  [2:0]        relayOut,
  output reg               analogAsLogicOut,
  // status
  output reg               motorEnable,
  output reg               damperStuckFault,
  output reg               damperOpenFault,
  output reg               irq
);

  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_OPEN  = 3'd1;
  localparam [2:0] S_RUN   = 3'd2;
  localparam [2:0] S_CLOSE = 3'd3;
  localparam [2:0] S_FAULT = 3'd4;

  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  reg [3:0]        outSel_r;
  reg [3:0]        fbSel_r;
  reg              fbSup_r;
  reg              pol_r;
  reg              fbCmd_r;
  reg [15:0]       openDly_r;
  reg [15:0]       closeDly_r;
  reg [3:0]        irqStat_r;
  reg [3:0]        irqEn_r;
  reg [2:0]        state_r;
  reg [TICK_W-1:0] tickCnt_r;
  reg [15:0]       tmr_r;

  reg [2:0]        stateNxt;
  reg              setStuck;
  reg              setOpen;
  reg [3:0]        events;
  reg [3:0]        irqStatNxt;
  reg              cmdNxt;

  wire             enabled;
  wire             fbSup;
  wire             fbOpen;
  wire             faultRst;
  wire             tick;
  wire             reload;
  wire             openTimeout;
  wire             closeTimeout;

  function [15:0] clampDly;
    input [31:0] v;
    input [31:0] lo;
    begin
      if (v < lo) begin
        clampDly = lo[15:0];
      end else if (v > `DMP_DLY_MAX) begin
        clampDly = `DMP_DLY_MAX;
      end else begin
        clampDly = v[15:0];
      end
    end
  endfunction

  function fbLevel;
    input [3:0]        sel;
    input [NUM_LI-1:0] li;
    input              cmdBit;
    integer            i;
    begin
      fbLevel = 1'b0;
      if (sel == `DMP_FB_CMDBIT) begin
        fbLevel = cmdBit;
      end
      for (i = 0; i < NUM_LI; i = i + 1) begin
        if (sel == i + 1) begin
          fbLevel = li[i];
        end
      end
    end
  endfunction

  // analog destination only counts while the analog output is free
  assign enabled = (outSel_r >= `DMP_OUT_LOGIC_FIRST && outSel_r <= `DMP_OUT_RELAY_FOURTH) ||
                   (outSel_r == `DMP_OUT_ANA && !analogAssigned);

  assign fbSup = enabled && (fbSel_r != `DMP_FB_NONE);

  // polarity clear means level 0 reads as open
  assign fbOpen = pol_r ? fbLevel(fbSel_r, logicIn, fbCmd_r)
                        : ~fbLevel(fbSel_r, logicIn, fbCmd_r);

  assign faultRst = wrStb && regAddr == `DMP_FAULT_RST && wrData[0];

  assign tick = (tickCnt_r == TICK_LAST[TICK_W-1:0]);

  // timers restart whenever the sequence enters a supervised phase
  assign reload = (stateNxt == S_OPEN && state_r != S_OPEN) ||
                  (stateNxt == S_CLOSE && state_r != S_CLOSE);

  assign openTimeout  = (tmr_r >= openDly_r);
  assign closeTimeout = (tmr_r >= closeDly_r);

  always @* begin
    stateNxt = state_r;
    setStuck = 1'b0;
    setOpen  = 1'b0;
    events   = 4'h0;
    case (state_r)
      S_IDLE: begin
        if (fbSup && !fbSup_r && fbOpen) begin
          setOpen  = 1'b1;
          stateNxt = S_FAULT;
        end else if (runCmd && enabled) begin
          if (fbSup && closeDly_r == 16'h0000 && fbOpen) begin
            setOpen  = 1'b1;
            stateNxt = S_FAULT;
          end else begin
            stateNxt = S_OPEN;
          end
        end
      end
      S_OPEN: begin
        if (!runCmd) begin
          stateNxt = S_CLOSE;
        end else if (!fbSup || fbOpen) begin
          stateNxt = S_RUN;
          events[`DMP_EV_RUN] = 1'b1;
        end else if (openTimeout) begin
          setStuck = 1'b1;
          stateNxt = S_FAULT;
        end
      end
      S_RUN: begin
        if (!runCmd) begin
          stateNxt = S_CLOSE;
        end
      end
      S_CLOSE: begin
        if (runCmd) begin
          stateNxt = S_OPEN;
        end else if (!fbSup || !fbOpen || closeDly_r == 16'h0000) begin
          // zero delay defers the check to the next run
          stateNxt = S_IDLE;
          events[`DMP_EV_CLOSED] = 1'b1;
        end else if (closeTimeout) begin
          setOpen  = 1'b1;
          stateNxt = S_FAULT;
        end
      end
      S_FAULT: begin
        // run must be removed so the fault cannot restart the fan unseen
        if (faultRst && !runCmd) begin
          stateNxt = S_IDLE;
        end
      end
      default: begin
        stateNxt = S_IDLE;
      end
    endcase
    if (!enabled && stateNxt != S_FAULT) begin
      stateNxt = S_IDLE;
    end
    events[`DMP_EV_STUCK] = setStuck;
    events[`DMP_EV_OPEN]  = setOpen;
  end

  // opening command exists only while opening or running
  always @* begin
    cmdNxt = (stateNxt == S_OPEN) || (stateNxt == S_RUN);
  end

  // a new event wins over a clear in the same cycle
  always @* begin
    irqStatNxt = irqStat_r;
    if (wrStb && regAddr == `DMP_IRQ_CLR) begin
      irqStatNxt = irqStatNxt & ~wrData[3:0];
    end
    irqStatNxt = irqStatNxt | events;
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      state_r   <= S_IDLE;
      tickCnt_r <= {TICK_W{1'b0}};
      tmr_r     <= 16'h0000;
      fbSup_r   <= 1'b0;
    end else begin
      state_r <= stateNxt;
      fbSup_r <= fbSup;
      if (reload || tick) begin
        tickCnt_r <= {TICK_W{1'b0}};
      end else begin
        tickCnt_r <= tickCnt_r + 1'b1;
      end
      if (reload) begin
        tmr_r <= 16'h0000;
      end else if (tick && tmr_r != 16'hffff) begin
        tmr_r <= tmr_r + 16'h0001;
      end
    end
  end

  // settings other than the destination and interrupt enable are locked while unassigned
  always @(posedge ref_clk) begin
    if (srst) begin
      outSel_r   <= `DMP_OUT_NONE;
      fbSel_r    <= `DMP_FB_NONE;
      pol_r      <= `DMP_POL_RST;
      fbCmd_r    <= 1'b0;
      openDly_r  <= `DMP_DLY_RST;
      closeDly_r <= `DMP_DLY_RST;
      irqEn_r    <= 4'h0;
    end else if (wrStb) begin
      case (regAddr)
        `DMP_OUT_SEL: begin
          outSel_r <= wrData[3:0];
        end
        `DMP_IRQ_EN: begin
          irqEn_r <= wrData[3:0];
        end
        `DMP_FB_SEL: begin
          if (enabled) begin
            fbSel_r <= wrData[3:0];
          end
        end
        `DMP_POLARITY: begin
          if (enabled) begin
            pol_r <= wrData[0];
          end
        end
        `DMP_OPEN_DLY: begin
          if (enabled) begin
            openDly_r <= clampDly(wrData, `DMP_DLY_MIN_O);
          end
        end
        `DMP_CLOSE_DLY: begin
          if (enabled) begin
            closeDly_r <= clampDly(wrData, `DMP_DLY_MIN_C);
          end
        end
        `DMP_FB_CMD: begin
          if (enabled) begin
            fbCmd_r <= wrData[0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      irqStat_r <= 4'h0;
      irq       <= 1'b0;
    end else begin
      irqStat_r <= irqStatNxt;
      irq       <= |(irqStatNxt & irqEn_r);
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      logicOut         <= 4'h0;
      relayOut         <= 3'h0;
      analogAsLogicOut <= 1'b0;
      motorEnable      <= 1'b0;
      damperStuckFault <= 1'b0;
      damperOpenFault  <= 1'b0;
    end else begin
      logicOut <= 4'h0;
      relayOut <= 3'h0;
      analogAsLogicOut <= 1'b0;
      if (cmdNxt) begin
        if (outSel_r <= `DMP_OUT_LOGIC_FOURTH) begin
          logicOut[outSel_r[1:0] - 2'd1] <= 1'b1;
        end else if (outSel_r <= `DMP_OUT_RELAY_FOURTH) begin
          relayOut[outSel_r[1:0] - 2'd1] <= 1'b1;
        end else begin
          analogAsLogicOut <= 1'b1;
        end
      end
      motorEnable <= (stateNxt == S_RUN);
      if (stateNxt == S_IDLE && state_r == S_FAULT) begin
        damperStuckFault <= 1'b0;
        damperOpenFault  <= 1'b0;
      end else begin
        damperStuckFault <= damperStuckFault | setStuck;
        damperOpenFault  <= damperOpenFault | setOpen;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      rdData <= 32'h00000000;
    end else begin
      rdData <= 32'h00000000;
      if (rdStb) begin
        case (regAddr)
          `DMP_OUT_SEL: begin
            rdData <= {28'h0000000, outSel_r};
          end
          `DMP_FB_SEL: begin
            rdData <= enabled ? {28'h0000000, fbSel_r} : 32'h00000000;
          end
          `DMP_POLARITY: begin
            rdData <= enabled ? {31'h0, pol_r} : 32'h00000000;
          end
          `DMP_OPEN_DLY: begin
            rdData <= enabled ? {16'h0000, openDly_r} : 32'h00000000;
          end
          `DMP_CLOSE_DLY: begin
            rdData <= enabled ? {16'h0000, closeDly_r} : 32'h00000000;
          end
          `DMP_FB_CMD: begin
            rdData <= enabled ? {31'h0, fbCmd_r} : 32'h00000000;
          end
          `DMP_STATUS: begin
            rdData <= {23'h0, state_r, enabled, fbSup && fbOpen,
                       damperOpenFault, damperStuckFault, motorEnable,
                       cmdNxt};
          end
          `DMP_IRQ_STAT: begin
            rdData <= {28'h0000000, irqStat_r};
          end
          `DMP_IRQ_EN: begin
            rdData <= {28'h0000000, irqEn_r};
          end
          default: begin
            rdData <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// [damper_map.vh]
/*
 damper supervisor constants: register offsets, field codes, reset values,
 timing. assumes a 100 MHz ref_clk and a byte-addressed register port.
*/
// Functional notes
// - opening output drops as soon as the internal opening command goes away
// - command goes to one selected output; none selected disables the function
// - analog output acts as logic output only while it has no analog use
// - feedback from one logic input or command bit; none means no supervision
// - polarity picks whether level 0 or 1 means open; default 0
// - motor starts only when feedback reaches its active open level
// - no open indication before opening delay ends locks damper stuck fault
// - opening delay 0.05 s to 300 s, default 60 s
// - still open when closing delay ends after stop locks damper open fault
// - closing delay 0.00 s to 300 s, default 60 s
// - zero closing delay checks open fault only at run, before output
// - feedback not matching polarity at assignment may fault at once
`ifndef DAMPER_MAP_VH
`define DAMPER_MAP_VH

`define DMP_OUT_SEL    6'h00
`define DMP_FB_SEL     6'h04
`define DMP_POLARITY   6'h08
`define DMP_OPEN_DLY   6'h0c
`define DMP_CLOSE_DLY  6'h10
`define DMP_STATUS     6'h14
`define DMP_IRQ_STAT   6'h18
`define DMP_IRQ_CLR    6'h1c
`define DMP_IRQ_EN     6'h20
`define DMP_FAULT_RST  6'h24
`define DMP_FB_CMD     6'h28

`define DMP_OUT_NONE   4'h0
`define DMP_OUT_LOGIC_FIRST  4'h1
`define DMP_OUT_LOGIC_FOURTH 4'h4
`define DMP_OUT_RELAY_SECOND 4'h5
`define DMP_OUT_RELAY_FOURTH 4'h7
`define DMP_OUT_ANA    4'h8
`define DMP_FB_NONE    4'h0
`define DMP_FB_CMDBIT  4'hf

`define DMP_POL_RST    1'b0
`define DMP_DLY_MIN_O  32'd5
`define DMP_DLY_MIN_C  32'd0
`define DMP_DLY_MAX    16'd30000
`define DMP_DLY_RST    16'h1770

`define DMP_CLK_NS     10
`define DMP_TICK_NS    10000000

`define DMP_EV_STUCK   0
`define DMP_EV_OPEN    1
`define DMP_EV_RUN     2
`define DMP_EV_CLOSED  3

`endif

// [damper_control_supervisor_properties.sv]
/*
 port checker for the damper supervisor, bound to every instance.
 assumes TICK_CYCLES and opening delay keep a stuck fault over 8 cycles off.
*/
`timescale 1ns/1ps
`default_nettype none
module damper_control_supervisor_properties (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       srst,
  // inputs
  input wire logic       wrStb,
  input wire logic       runCmd,
  input wire logic       analogAssigned,
  // outputs
  input wire logic [3:0] logicOut,
  input wire logic [2:0] relayOut,
  input wire logic       analogAsLogicOut,
  input wire logic       motorEnable,
  input wire logic       damperStuckFault,
  input wire logic       damperOpenFault
);
  wire [7:0] outs = {logicOut, relayOut, analogAsLogicOut};
  wire       anyFault = damperStuckFault | damperOpenFault;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  cmd_drop_a: assert property (!runCmd |=> outs == 8'h00)
    else $error("opening output held without run");
  cmd_cause_a: assert property (outs != 8'h00 |-> $past(runCmd))
    else $error("opening output without run");
  one_dest_a: assert property ($onehot0(outs))
    else $error("more than one destination driven");
  analog_busy_a: assert property (analogAssigned |=> !analogAsLogicOut)
    else $error("analog output used while assigned");
  motor_cause_a: assert property ($rose(motorEnable) |-> $past(runCmd) && outs != 8'h00)
    else $error("motor started without opening command");
  fault_lock_a: assert property (anyFault && $past(anyFault) |->
    !motorEnable && outs == 8'h00)
    else $error("outputs active in fault");
  stuck_hold_a: assert property (damperStuckFault && !wrStb |=> damperStuckFault)
    else $error("stuck fault dropped without reset write");
  open_hold_a: assert property (damperOpenFault && !wrStb |=> damperOpenFault)
    else $error("open fault dropped without reset write");
  stuck_early_a: assert property ($rose(runCmd) && !damperStuckFault |=>
    !damperStuckFault [*8])
    else $error("stuck fault before minimum delay");
  cover property ($rose(motorEnable));
  cover property ($rose(damperStuckFault));
  cover property ($rose(damperOpenFault));
endmodule
bind damper_control_supervisor damper_control_supervisor_properties chk (
  .ref_clk(ref_clk), .srst(srst), .wrStb(wrStb), .runCmd(runCmd),
  .analogAssigned(analogAssigned), .logicOut(logicOut), .relayOut(relayOut),
  .analogAsLogicOut(analogAsLogicOut), .motorEnable(motorEnable),
  .damperStuckFault(damperStuckFault), .damperOpenFault(damperOpenFault)
);
`default_nettype wire

// [damper_actuator.sv]
/*
 behavioural damper with an open-position contact.
 assumes openCmd is the OR of all destination outputs of the supervisor.
*/
`timescale 1ns/1ps
`default_nettype none
module damper_actuator #(
  parameter int TRAVEL = 8
) (
  // clock
  input  wire logic clk,
  // control
  input  wire logic openCmd,
  input  wire logic jam,
  input  wire logic pol,
  // contact
  output var  logic fbLevel
);
  logic [3:0] pos_r = 4'h0;
  // travel kept well under both delays so a healthy damper never faults
  always @(posedge clk) begin
    if (!jam && openCmd && pos_r != TRAVEL[3:0])
      pos_r <= pos_r + 4'h1;
    else if (!jam && !openCmd && pos_r != 4'h0)
      pos_r <= pos_r - 4'h1;
  end
  // contact reads open only at full travel
  assign fbLevel = (pos_r == TRAVEL[3:0]) ? pol : ~pol;
endmodule
`default_nettype wire

// [test_damper_control_supervisor.sv]
/*
 self-checking bench for the damper supervisor with a damper model.
 assumes TICK_CYCLES of 4, so a tick is 40 ns.
*/
`timescale 1ns/1ps
`default_nettype none
`include "damper_map.vh"
module test_damper_control_supervisor;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  regAddr = 6'h00;
  logic [31:0] wrData = 32'h0;
  logic        wrStb = 1'b0, rdStb = 1'b0, runCmd = 1'b0;
  logic        analogAssigned = 1'b0, jam = 1'b0, pol = 1'b0;
  logic [4:0]  liSpare = 5'h00;
  logic [31:0] rv;
  wire  [31:0] rdData;
  wire  [3:0]  logicOut;
  wire  [2:0]  relayOut;
  wire         analogAsLogicOut, motorEnable, damperStuckFault, damperOpenFault, irq, fbLevel;
  int          n_fail = 0;
  int          n_checks = 0;
  // destination, analog in use, expected {logicOut, relayOut, analogAsLogicOut}
  logic [12:0] rows [11] = '{{4'h1, 1'b0, 8'h10}, {4'h2, 1'b0, 8'h20}, {4'h3, 1'b0, 8'h40},
    {4'h4, 1'b0, 8'h80}, {4'h5, 1'b0, 8'h02}, {4'h6, 1'b0, 8'h04}, {4'h7, 1'b0, 8'h08},
    {4'h8, 1'b0, 8'h01}, {4'h8, 1'b1, 8'h00}, {4'h9, 1'b0, 8'h00}, {4'h1, 1'b0, 8'h10}};
  always #5 ref_clk = ~ref_clk;
  damper_control_supervisor #(.TICK_CYCLES(4)) uut (
    .ref_clk(ref_clk), .srst(srst), .regAddr(regAddr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .runCmd(runCmd), .analogAssigned(analogAssigned),
    .logicIn({liSpare, fbLevel}), .logicOut(logicOut), .relayOut(relayOut),
    .analogAsLogicOut(analogAsLogicOut), .motorEnable(motorEnable),
    .damperStuckFault(damperStuckFault), .damperOpenFault(damperOpenFault), .irq(irq));
  damper_actuator model (.clk(ref_clk), .openCmd(|{logicOut, relayOut, analogAsLogicOut}),
    .jam(jam), .pol(pol), .fbLevel(fbLevel));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge ref_clk);
    wrStb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    rdStb <= 1'b1;
    @(posedge ref_clk);
    rdStb <= 1'b0;
    #1 rv = rdData;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic set(input logic r, input logic j);
    @(posedge ref_clk);
    runCmd <= r;
    jam <= j;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    cyc(1);
    chk("reset outputs", {damperStuckFault, damperOpenFault, motorEnable, irq, logicOut}, 0);
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge ref_clk);
      analogAssigned <= rows[i][8];
      wr(`DMP_OUT_SEL, rows[i][12:9]);
      rd(`DMP_OPEN_DLY);
      chk("open delay", rv, (rows[i][7:0] != 8'h00) ? 32'h1770 : 32'h0);
      set(1'b1, 1'b0);
      cyc(3);
      chk("outputs", {logicOut, relayOut, analogAsLogicOut}, rows[i][7:0]);
      chk("motor", motorEnable, |rows[i][7:0]);
      set(1'b0, 1'b0);
      cyc(3);
      chk("outputs off", {logicOut, relayOut, analogAsLogicOut}, 0);
    end
    $display("test destinations done");
    rd(`DMP_POLARITY);
    chk("polarity", rv, 0);
    wr(`DMP_OPEN_DLY, 32'h1);
    rd(`DMP_OPEN_DLY);
    chk("open delay min", rv, 32'h5);
    wr(`DMP_OPEN_DLY, 32'h9c40);
    rd(`DMP_OPEN_DLY);
    chk("open delay max", rv, 32'h7530);
    wr(`DMP_CLOSE_DLY, 32'h0);
    rd(`DMP_CLOSE_DLY);
    chk("close delay min", rv, 0);
    rd(6'h3c);
    chk("unmapped", rv, 0);
    $display("test registers done");
    @(posedge ref_clk);
    pol <= 1'b1;
    wr(`DMP_POLARITY, 32'h1);
    wr(`DMP_OPEN_DLY, 32'h5);
    wr(`DMP_CLOSE_DLY, 32'h5);
    wr(`DMP_FB_SEL, 32'h1);
    cyc(2);
    chk("no fault on match", {damperStuckFault, damperOpenFault}, 0);
    set(1'b1, 1'b0);
    cyc(3);
    chk("motor waits", motorEnable, 0);
    for (int k = 0; k < 40 && motorEnable !== 1'b1; k++)
      cyc(1);
    chk("motor after open", motorEnable, 1);
    set(1'b0, 1'b0);
    cyc(40);
    chk("clean close", {damperStuckFault, damperOpenFault}, 0);
    $display("test feedback done");
    wr(`DMP_IRQ_EN, 32'h1);
    set(1'b1, 1'b1);
    cyc(12);
    chk("stuck early", damperStuckFault, 0);
    cyc(30);
    chk("stuck fault", damperStuckFault, 1);
    chk("stuck outputs", {logicOut, motorEnable}, 0);
    chk("irq raised", irq, 1);
    rd(`DMP_IRQ_STAT);
    chk("irq status", rv[0], 1);
    wr(`DMP_IRQ_CLR, 32'h1);
    cyc(2);
    chk("irq cleared", irq, 0);
    set(1'b0, 1'b0);
    wr(`DMP_FAULT_RST, 32'h1);
    cyc(2);
    chk("stuck reset", damperStuckFault, 0);
    $display("test stuck done");
    set(1'b1, 1'b0);
    cyc(40);
    set(1'b0, 1'b1);
    cyc(45);
    chk("open fault", damperOpenFault, 1);
    chk("irq masked", irq, 0);
    wr(`DMP_CLOSE_DLY, 32'h0);
    wr(`DMP_FAULT_RST, 32'h1);
    cyc(2);
    chk("no check at stop", damperOpenFault, 0);
    set(1'b1, 1'b1);
    cyc(3);
    chk("open fault at run", damperOpenFault, 1);
    chk("no output", logicOut, 0);
    set(1'b0, 1'b0);
    wr(`DMP_FAULT_RST, 32'h1);
    cyc(20);
    $display("test open done");
    wr(`DMP_FB_SEL, 32'h0);
    wr(`DMP_POLARITY, 32'h0);
    cyc(2);
    chk("unsupervised", damperOpenFault, 0);
    wr(`DMP_FB_SEL, 32'h1);
    cyc(2);
    chk("assign mismatch", damperOpenFault, 1);
    $display("test assignment done");
    rd(`DMP_IRQ_STAT);
    chk("irq status bits", rv, 32'he);
    wr(`DMP_FAULT_RST, 32'h1);
    wr(`DMP_FB_SEL, 32'h0);
    wr(`DMP_POLARITY, 32'h1);
    wr(`DMP_FB_SEL, `DMP_FB_CMDBIT);
    set(1'b1, 1'b0);
    cyc(4);
    chk("cmd bit waits", motorEnable, 0);
    wr(`DMP_FB_CMD, 32'h1);
    cyc(3);
    chk("cmd bit open", motorEnable, 1);
    rd(`DMP_STATUS);
    chk("status", rv, 32'hb3);
    $display("test command bit done");
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    cyc(1);
    chk("reset mid run", {motorEnable, damperOpenFault, irq, logicOut}, 0);
    rd(`DMP_OUT_SEL);
    chk("reset destination", rv, 0);
    set(1'b0, 1'b0);
    cyc(2);
    $display("test reset again done");
    test_done();
  end
endmodule
`default_nettype wire
